//--- rtl/dtpm_defs.vh
// constants for the drive trip priority manager
`ifndef DTPM_DEFS_VH
`define DTPM_DEFS_VH
`define DTPM_CLK_HZ 10000000
`define DTPM_MS_PER_TICK 100
`define DTPM_TICK_CYCLES (`DTPM_CLK_HZ / 1000 * `DTPM_MS_PER_TICK)
`define DTPM_RESET_DELAY_MS 1000
`define DTPM_OI_DELAY_MS 10000
`define DTPM_OHT_STOP_MS 10000
`define DTPM_RESET_TICKS (`DTPM_RESET_DELAY_MS / `DTPM_MS_PER_TICK)
`define DTPM_OI_TICKS (`DTPM_OI_DELAY_MS / `DTPM_MS_PER_TICK)
`define DTPM_OHT_TICKS (`DTPM_OHT_STOP_MS / `DTPM_MS_PER_TICK)
// register byte offsets
`define DTPM_REG_CODE 4'h0
`define DTPM_REG_INFO 4'h4
`define DTPM_REG_STAMP 4'h8
`define DTPM_REG_CTRL 4'hc
// trip codes
`define DTPM_CODE_UV 8'h01
`define DTPM_CODE_OV 8'h02
`define DTPM_CODE_OUTPUT_OVERCURRENT_TRIP 8'h03
`define DTPM_CODE_BRAKING_OVERCURRENT_TRIP 8'h04
`define DTPM_CODE_PS24 8'h09
`define DTPM_CODE_TUNE_LO 8'h0b
`define DTPM_CODE_TUNE_HI 8'h12
`define DTPM_CODE_OLD1 8'h1a
`define DTPM_CODE_OHT3 8'h1b
`define DTPM_CODE_CL2 8'h1c
`define DTPM_CODE_SCL 8'h1e
`define DTPM_CODE_EEF 8'h1f
`define DTPM_CODE_PH 8'h20
`define DTPM_CODE_PM_LO 8'h65
`define DTPM_CODE_OHT4P 8'h66
`define DTPM_CODE_OIBRP 8'h67
`define DTPM_CODE_OIACP 8'h68
`define DTPM_CODE_PHP 8'h6b
`define DTPM_CODE_OIDCP 8'h6d
`define DTPM_CODE_UNIDP 8'h6e
`define DTPM_CODE_PM_HI 8'h6e
`define DTPM_CODE_ENC11 8'ha1
`define DTPM_CODE_ENC17 8'ha7
`define DTPM_CODE_CARD_LO 8'haf
`define DTPM_CODE_CARD_HI 8'hbc
`define DTPM_CODE_ENCODER_TRIP_ONE 8'hbd
`define DTPM_CODE_ENC2 8'hbe
`define DTPM_CODE_ENC8 8'hc4
`define DTPM_CODE_SLHF1 8'hc8
`define DTPM_CODE_SLHF2 8'hcd
`define DTPM_CODE_SLHF3 8'hd2
`define DTPM_CODE_HF_BASE 8'hc8
`define DTPM_DEFAULTS_CODE 16'h03e8
`endif

//--- rtl/dtpm_tick_counter.v
// saturating tick counter used for trip age and stop timeout
`timescale 1ns/10ps
`include "dtpm_defs.vh"
module dtpm_tick_counter (
  input wire ref_clk_i,
  input wire rst_b_i,
  input wire clear_i,
  input wire tick_i,
  output reg [15:0] count_o
);
  // saturate so very old trips never wrap back to young
  always @(posedge ref_clk_i) begin
    if (!rst_b_i || clear_i) begin
      count_o <= 16'h0000;
    end else if (tick_i && count_o != 16'hffff) begin
      count_o <= count_o + 16'h0001;
    end
  end
endmodule

//--- rtl/dtpm_sync2.v
// two-flop synchroniser for a bus of pin inputs
`timescale 1ns/10ps
module dtpm_sync2 #(
  parameter W = 8
) (
  input wire ref_clk_i,
  input wire rst_b_i,
  input wire [W-1:0] async_i,
  output reg [W-1:0] sync_o
);
  reg [W-1:0] meta_reg;
  // first stage feeds only the second stage
  always @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      meta_reg <= {W{1'b0}};
      sync_o <= {W{1'b0}};
    end else begin
      meta_reg <= async_i;
      sync_o <= meta_reg;
    end
  end
endmodule

//--- rtl/dtpm_top.v
// drive trip priority manager with avalon register slave
//
// The Avalon-MM register port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`include "dtpm_defs.vh"
module dtpm_top (
  input wire ref_clk_i,
  input wire rst_b_i,
  // trip request from monitors
  input wire trip_req_i,
  input wire [7:0] trip_code_i,
  input wire [3:0] trip_module_i,
  // status pins from outside the clock domain
  input wire power_up_i,
  input wire parallel_if_i,
  input wire supply_ok_i,
  input wire motor_stopped_i,
  input wire safe_torque_off_i,
  input wire [3:0] module_mains_loss_i,
  input wire [3:0] module_phase_loss_i,
  input wire [3:0] module_present_i,
  // avalon-mm slave
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // drive status
  output reg trip_active_o,
  output reg drive_inactive_o,
  output reg stop_request_o,
  output reg run_permit_o,
  output reg dc_bus_mains_loss_o,
  output reg [3:0] display_module_o
);
  localparam ST_IDLE = 3'b001;
  localparam ST_STOP = 3'b010;
  localparam ST_TRIP = 3'b100;

  wire [15:0] sync_bits;
  wire pu_s = sync_bits[0];
  wire par_s = sync_bits[1];
  wire sup_s = sync_bits[2];
  wire stop_s = sync_bits[3];
  wire sto_s = sync_bits[4];
  wire [3:0] ml_s = sync_bits[8:5];
  wire [3:0] pl_s = sync_bits[12:9];
  wire [3:0] pres_s;

  dtpm_sync2 #(.W(16)) u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .async_i({3'b000, module_phase_loss_i, module_mains_loss_i, safe_torque_off_i,
      motor_stopped_i, supply_ok_i, parallel_if_i, power_up_i}),
    .sync_o(sync_bits)
  );
  dtpm_sync2 #(.W(4)) u_sync_pres (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .async_i(module_present_i),
    .sync_o(pres_s)
  );

  reg [2:0] state_reg;
  reg [7:0] code_reg;
  reg [2:0] cat_reg;
  reg [3:0] module_reg;
  reg [31:0] stamp_reg;
  reg [31:0] time_reg;
  reg [23:0] pre_reg;
  reg tick_reg;
  reg [7:0] pend_code_reg;
  reg [3:0] pend_module_reg;
  reg [2:0] pend_cat_reg;
  reg defaults_reg;
  reg [3:0] stop_cfg_reg;
  reg tune_lock_reg;
  reg run_en_reg;
  reg reset_req_reg;
  reg reset_refused_reg;
  reg php_reg;
  reg avs_waitrequest_next;
  reg pend_bus_reg;

  wire [15:0] age;
  wire [15:0] stop_age;
  wire age_clear = (state_reg != ST_TRIP);
  wire stop_clear = (state_reg != ST_STOP);

  dtpm_tick_counter u_age (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .clear_i(age_clear),
    .tick_i(tick_reg),
    .count_o(age)
  );
  dtpm_tick_counter u_stop (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .clear_i(stop_clear),
    .tick_i(tick_reg),
    .count_o(stop_age)
  );

  // category of a code, 1 most important
  function [2:0] cat_of;
    input [7:0] c;
    input pu;
    begin
      if (c >= 8'hd9) begin
        cat_of = 3'd2;
      end else if (c == `DTPM_CODE_SLHF1 || c == `DTPM_CODE_SLHF2 ||
                   c == `DTPM_CODE_SLHF3) begin
        cat_of = 3'd2;
      end else if (c == `DTPM_CODE_EEF) begin
        cat_of = 3'd3;
      end else if (c >= `DTPM_CODE_CARD_LO && c <= `DTPM_CODE_CARD_HI && c != 8'hb0) begin
        cat_of = pu ? 3'd5 : 3'd4;
      end else if (c == `DTPM_CODE_PS24 || c == `DTPM_CODE_ENCODER_TRIP_ONE) begin
        cat_of = 3'd4;
      end else if (c == `DTPM_CODE_UV) begin
        cat_of = 3'd6;
      end else begin
        cat_of = 3'd5;
      end
    end
  endfunction

  // encoder trips that the encoder supply trip may override
  function enc_low;
    input [7:0] c;
    begin
      enc_low = (c >= `DTPM_CODE_ENC2 && c <= `DTPM_CODE_ENC8) ||
                (c >= `DTPM_CODE_ENC11 && c <= `DTPM_CODE_ENC17);
    end
  endfunction

  // request code; hardware faults 1..16 arrive as 0xf0|n
  wire hf_low = (trip_code_i[7:4] == 4'hf);
  wire is_pm = trip_code_i >= `DTPM_CODE_PM_LO && trip_code_i <= `DTPM_CODE_PM_HI;
  wire pm_single_ok = trip_code_i == `DTPM_CODE_OIDCP || trip_code_i == `DTPM_CODE_OHT4P ||
                      trip_code_i == `DTPM_CODE_UNIDP;
  // module trips without the parallel interface are limited
  wire pm_ok = !is_pm || par_s || pm_single_ok;
  wire [2:0] req_cat = hf_low ? 3'd1 : cat_of(trip_code_i, pu_s);
  wire [3:0] req_mod = (is_pm && par_s) ? trip_module_i : 4'h0;

  // module mains loss: partial loss trips, total loss goes to bus logic
  wire ml_any = |(ml_s & pres_s);
  wire ml_all = ((ml_s & pres_s) == pres_s) && (pres_s != 4'h0);
  wire php_now = (ml_any && !ml_all) || |(pl_s & pres_s);

  wire new_valid = php_now && !php_reg ? 1'b1 : (trip_req_i && pm_ok);
  wire [7:0] new_code = (php_now && !php_reg) ? `DTPM_CODE_PHP : trip_code_i;
  wire [2:0] new_cat = (php_now && !php_reg) ? 3'd5 : req_cat;
  wire [3:0] new_mod = (php_now && !php_reg) ? 4'h0 : req_mod;

  // override test against the trip now held
  reg accept;
  always @* begin
    accept = 1'b0;
    if (new_valid) begin
      if (state_reg == ST_IDLE) begin
        accept = 1'b1;
      end else if (new_cat < cat_reg) begin
        // encoder supply trips beat only a subset of category five
        if ((new_code == `DTPM_CODE_PS24 || new_code == `DTPM_CODE_ENCODER_TRIP_ONE) && cat_reg == 3'd5) begin
          accept = enc_low(code_reg);
        end else begin
          accept = 1'b1;
        end
      end
    end
  end

  wire stop_first = ((new_code == `DTPM_CODE_OLD1 || (new_code >= `DTPM_CODE_CL2 &&
                     new_code <= `DTPM_CODE_SCL)) && stop_cfg_reg[0]) ||
                    new_code == `DTPM_CODE_PH || new_code == `DTPM_CODE_OHT3;

  // may a user reset clear the held trip now
  reg reset_ok;
  always @* begin
    reset_ok = 1'b0;
    if (cat_reg == 3'd1 || cat_reg == 3'd2 || cat_reg == 3'd6) begin
      reset_ok = 1'b0;
    end else if (code_reg == `DTPM_CODE_EEF) begin
      reset_ok = defaults_reg && age >= `DTPM_RESET_TICKS;
    end else if (code_reg == `DTPM_CODE_OUTPUT_OVERCURRENT_TRIP || code_reg == `DTPM_CODE_BRAKING_OVERCURRENT_TRIP ||
                 code_reg == `DTPM_CODE_OIACP || code_reg == `DTPM_CODE_OIBRP ||
                 code_reg == `DTPM_CODE_OIDCP) begin
      reset_ok = age >= `DTPM_OI_TICKS;
    end else begin
      reset_ok = age >= `DTPM_RESET_TICKS;
    end
  end

  wire is_tune = code_reg >= `DTPM_CODE_TUNE_LO && code_reg <= `DTPM_CODE_TUNE_HI;
  wire disabled = sto_s || !run_en_reg;

  // seconds-scale prescaler, one tick per 100 ms
  always @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      pre_reg <= 24'h000000;
      tick_reg <= 1'b0;
      time_reg <= 32'h00000000;
    end else if (pre_reg == `DTPM_TICK_CYCLES - 1) begin
      pre_reg <= 24'h000000;
      tick_reg <= 1'b1;
      time_reg <= time_reg + 32'h00000001;
    end else begin
      pre_reg <= pre_reg + 24'h000001;
      tick_reg <= 1'b0;
    end
  end

  // trip state machine
  always @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      state_reg <= ST_IDLE;
      code_reg <= 8'h00;
      cat_reg <= 3'd7;
      module_reg <= 4'h0;
      stamp_reg <= 32'h00000000;
      pend_code_reg <= 8'h00;
      pend_cat_reg <= 3'd7;
      pend_module_reg <= 4'h0;
      tune_lock_reg <= 1'b0;
      reset_refused_reg <= 1'b0;
      php_reg <= 1'b0;
    end else begin
      php_reg <= php_now;
      if (tune_lock_reg && disabled) begin
        tune_lock_reg <= 1'b0;
      end
      case (state_reg)
        ST_IDLE: begin
          if (accept && stop_first) begin
            state_reg <= ST_STOP;
            pend_code_reg <= new_code;
            pend_cat_reg <= new_cat;
            pend_module_reg <= new_mod;
          end else if (accept) begin
            state_reg <= ST_TRIP;
            code_reg <= new_code;
            cat_reg <= new_cat;
            module_reg <= new_mod;
            stamp_reg <= time_reg;
          end
        end
        ST_STOP: begin
          // overheat gives up waiting after the stop timeout
          if (stop_s || (pend_code_reg == `DTPM_CODE_OHT3 &&
              stop_age >= `DTPM_OHT_TICKS)) begin
            state_reg <= ST_TRIP;
            code_reg <= pend_code_reg;
            cat_reg <= pend_cat_reg;
            module_reg <= pend_module_reg;
            stamp_reg <= time_reg;
          end
        end
        ST_TRIP: begin
          if (accept) begin
            code_reg <= new_code;
            cat_reg <= new_cat;
            module_reg <= new_mod;
            stamp_reg <= time_reg;
          end else if (code_reg == `DTPM_CODE_UV && sup_s) begin
            state_reg <= ST_IDLE;
            cat_reg <= 3'd7;
            code_reg <= 8'h00;
          end else if (reset_req_reg) begin
            if (reset_ok) begin
              state_reg <= ST_IDLE;
              cat_reg <= 3'd7;
              code_reg <= 8'h00;
              module_reg <= 4'h0;
              tune_lock_reg <= is_tune;
              reset_refused_reg <= 1'b0;
            end else begin
              reset_refused_reg <= 1'b1;
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // avalon slave: two wait cycles then answer
  wire acc = (avs_read || avs_write) && avs_waitrequest;
  always @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
      defaults_reg <= 1'b0;
      stop_cfg_reg <= 4'h0;
      run_en_reg <= 1'b1;
      reset_req_reg <= 1'b0;
    end else begin
      reset_req_reg <= 1'b0;
      if (state_reg == ST_IDLE) begin
        defaults_reg <= 1'b0;
      end
      if (acc && !avs_waitrequest_next) begin
        avs_waitrequest <= 1'b0;
      end else begin
        avs_waitrequest <= 1'b1;
      end
      if (acc && !avs_waitrequest_next) begin
        case (avs_address)
          `DTPM_REG_CODE: avs_readdata <= {24'h000000, code_reg};
          `DTPM_REG_INFO: avs_readdata <= {16'h0000, reset_refused_reg, tune_lock_reg,
            state_reg, cat_reg, 4'h0, module_reg};
          `DTPM_REG_STAMP: avs_readdata <= stamp_reg;
          `DTPM_REG_CTRL: avs_readdata <= {26'h0000000, defaults_reg, run_en_reg, stop_cfg_reg};
          default: avs_readdata <= 32'h00000000;
        endcase
        if (avs_write && avs_address == `DTPM_REG_CTRL) begin
          stop_cfg_reg <= avs_writedata[3:0];
          run_en_reg <= avs_writedata[4];
          reset_req_reg <= avs_writedata[8];
          if (avs_writedata[31:16] == `DTPM_DEFAULTS_CODE) begin
            defaults_reg <= 1'b1;
          end
        end
      end
    end
  end

  // first two cycles of a request stall; next drops in the second, so the third cycle answers
  always @* begin
    avs_waitrequest_next = 1'b1;
    if ((avs_read || avs_write) && pend_bus_reg) begin
      avs_waitrequest_next = 1'b0;
    end
  end
  always @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      pend_bus_reg <= 1'b0;
    end else begin
      pend_bus_reg <= (avs_read || avs_write) && !pend_bus_reg;
    end
  end

  // registered status outputs
  always @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      trip_active_o <= 1'b0;
      drive_inactive_o <= 1'b0;
      stop_request_o <= 1'b0;
      run_permit_o <= 1'b0;
      dc_bus_mains_loss_o <= 1'b0;
      display_module_o <= 4'h0;
    end else begin
      trip_active_o <= (state_reg == ST_TRIP);
      drive_inactive_o <= (state_reg == ST_TRIP) && cat_reg == 3'd1;
      stop_request_o <= (state_reg == ST_STOP);
      run_permit_o <= (state_reg == ST_IDLE) && !tune_lock_reg && run_en_reg && !sto_s;
      dc_bus_mains_loss_o <= ml_all;
      display_module_o <= module_reg;
    end
  end
endmodule

//--- dv/dtpm_module_model.sv
// behavioural trip sources: internal monitors and parallel power modules
`timescale 1ns/10ps
module dtpm_module_model (
  input wire logic ref_clk_i,
  output logic trip_req_o,
  output logic [7:0] trip_code_o,
  output logic [3:0] trip_module_o,
  output logic [3:0] mains_loss_o,
  output logic [3:0] phase_loss_o,
  output logic [3:0] present_o
);
  // idle: single module present, no loss
  initial begin
    trip_req_o = 1'b0;
    trip_code_o = 8'h00;
    trip_module_o = 4'h0;
    present_o = 4'h1;
    mains_loss_o = 4'h0;
    phase_loss_o = 4'h0;
  end
  // one-cycle trip pulse; module number only on power module codes
  task automatic fire(input logic [7:0] c, input logic [3:0] m);
    trip_req_o <= 1'b1;
    trip_code_o <= c;
    trip_module_o <= (c >= 8'h65 && c <= 8'h6e) ? m : 4'h0;
    @(posedge ref_clk_i);
    trip_req_o <= 1'b0;
    trip_code_o <= ~c; // released lines never show a stale code
    trip_module_o <= ~m;
    @(posedge ref_clk_i);
  endtask
  // absent modules cannot report any loss
  task automatic mods(input logic [3:0] p, input logic [3:0] ml, input logic [3:0] pl);
    present_o <= p;
    mains_loss_o <= ml & p;
    phase_loss_o <= pl & p;
    @(posedge ref_clk_i);
  endtask
endmodule

//--- dv/dtpm_monitor.sv
// concurrent checks on the trip manager ports
`timescale 1ns/10ps
module dtpm_monitor (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic supply_ok_i,
  input wire logic parallel_if_i,
  input wire logic [3:0] module_mains_loss_i,
  input wire logic [3:0] module_present_i,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic trip_active_o,
  input wire logic drive_inactive_o,
  input wire logic stop_request_o,
  input wire logic run_permit_o,
  input wire logic dc_bus_mains_loss_o,
  input wire logic [3:0] display_module_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  localparam int RESET_CYC = 10000000; // 1 s at 10 MHz
  logic [31:0] age_reg;
  // trip age in clocks, saturating so it never wraps
  always @(posedge ref_clk_i) begin
    if (!rst_b_i || !trip_active_o) age_reg <= 32'h0;
    else if (age_reg < RESET_CYC) age_reg <= age_reg + 32'h1;
  end
  a_ack_needs_req: assert property (!avs_waitrequest |-> avs_read || avs_write)
    else $error("ack without request");
  a_ack_bounded: assert property ((avs_read || avs_write) |-> ##[0:3] !avs_waitrequest)
    else $error("bus answer late");
  a_unmapped_zero: assert property (
    avs_read && !avs_waitrequest && avs_address[1:0] != 2'b00 |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_inactive_tripped: assert property (drive_inactive_o |-> trip_active_o)
    else $error("inactive without trip");
  a_inactive_sticks: assert property (drive_inactive_o |=> drive_inactive_o)
    else $error("hardware fault cleared");
  a_inactive_no_run: assert property (drive_inactive_o |-> !run_permit_o)
    else $error("run permitted while inactive");
  a_module_zero: assert property (
    $rose(trip_active_o) && !parallel_if_i && !$past(parallel_if_i, 3)
    |-> display_module_o == 4'h0)
    else $error("module shown on single drive");
  a_all_loss_dcbus: assert property (
    (module_present_i != 4'h0 && module_mains_loss_i == module_present_i)[*5]
    |-> dc_bus_mains_loss_o)
    else $error("total loss not on dc bus path");
  a_part_loss_none: assert property (
    (module_mains_loss_i != module_present_i)[*5] |-> !dc_bus_mains_loss_o)
    else $error("partial loss on dc bus path");
  // only a supply that has just come back may clear a young trip
  a_early_clear: assert property (
    $fell(trip_active_o) |-> age_reg >= RESET_CYC
    || ($past(supply_ok_i) && !$past(supply_ok_i, 8)))
    else $error("trip cleared too early");
  a_stop_first: assert property ($rose(stop_request_o) |-> !trip_active_o)
    else $error("stop after trip");
  c_trip: cover property ($rose(trip_active_o));
  c_inactive: cover property ($rose(drive_inactive_o));
  c_clear: cover property ($fell(trip_active_o));
  c_stop: cover property ($rose(stop_request_o));
endmodule
bind dtpm_top dtpm_monitor mon (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
  .supply_ok_i(supply_ok_i), .parallel_if_i(parallel_if_i),
  .module_mains_loss_i(module_mains_loss_i), .module_present_i(module_present_i),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .trip_active_o(trip_active_o), .drive_inactive_o(drive_inactive_o),
  .stop_request_o(stop_request_o), .run_permit_o(run_permit_o),
  .dc_bus_mains_loss_o(dc_bus_mains_loss_o), .display_module_o(display_module_o));

//--- dv/tb_drive_trip_priority_manager.sv
// self-checking bench for the drive trip priority manager
`timescale 1ns/10ps
`include "dtpm_defs.vh"
module tb_drive_trip_priority_manager;
  logic ref_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic power_up_i = 1'b0, parallel_if_i = 1'b0, supply_ok_i = 1'b1;
  logic motor_stopped_i = 1'b0, safe_torque_off_i = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0, avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  wire trip_req_i;
  wire [7:0] trip_code_i;
  wire [3:0] trip_module_i, module_mains_loss_i, module_phase_loss_i, module_present_i;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, trip_active_o, drive_inactive_o, stop_request_o, run_permit_o;
  wire dc_bus_mains_loss_o;
  wire [3:0] display_module_o;
  logic [7:0] stops [3] = '{`DTPM_CODE_PH, `DTPM_CODE_SCL, `DTPM_CODE_OHT3};
  int num_errors = 0;
  int samples_checked = 0;
  // 10 MHz clock
  initial begin
    forever #50 ref_clk_i = ~ref_clk_i;
  end
  dtpm_top uut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .trip_req_i(trip_req_i),
    .trip_code_i(trip_code_i), .trip_module_i(trip_module_i), .power_up_i(power_up_i),
    .parallel_if_i(parallel_if_i), .supply_ok_i(supply_ok_i),
    .motor_stopped_i(motor_stopped_i), .safe_torque_off_i(safe_torque_off_i),
    .module_mains_loss_i(module_mains_loss_i), .module_phase_loss_i(module_phase_loss_i),
    .module_present_i(module_present_i), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .trip_active_o(trip_active_o),
    .drive_inactive_o(drive_inactive_o), .stop_request_o(stop_request_o),
    .run_permit_o(run_permit_o), .dc_bus_mains_loss_o(dc_bus_mains_loss_o),
    .display_module_o(display_module_o));
  dtpm_module_model pm (.ref_clk_i(ref_clk_i), .trip_req_o(trip_req_i),
    .trip_code_o(trip_code_i), .trip_module_o(trip_module_i),
    .mains_loss_o(module_mains_loss_i), .phase_loss_o(module_phase_loss_i),
    .present_o(module_present_i));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    q = avs_readdata;
    if (n >= 40) chk(32'h1, 32'h0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk_i);
  endtask
  task automatic reg_is(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q & m, e);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  // bounded wait for the trip flag, then compare
  task automatic flag_is(input logic want);
    int n;
    n = 0;
    while (trip_active_o !== want && n < 200) begin
      @(posedge ref_clk_i);
      n++;
    end
    chk({31'h0, trip_active_o}, {31'h0, want});
  endtask
  task automatic settle();
    repeat (6) @(posedge ref_clk_i);
  endtask
  task automatic hw_reset();
    rst_b_i <= 1'b0;
    repeat (8) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // a hang counts as a failure
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    num_errors++;
    summarize();
  end
  // main sequence
  initial begin
    @(posedge ref_clk_i);
    hw_reset();
    chk({29'h0, avs_waitrequest, trip_active_o, drive_inactive_o}, 32'h4);
    chk({31'h0, run_permit_o}, 32'h1);
    safe_torque_off_i <= 1'b1;
    settle();
    chk({31'h0, run_permit_o}, 32'h0);
    safe_torque_off_i <= 1'b0;
    reg_is(`DTPM_REG_CODE, 32'hffffffff, 32'h0);
    reg_is(4'h1, 32'hffffffff, 32'h0);
    pm.fire(`DTPM_CODE_OV, 4'h0);
    flag_is(1'b1);
    reg_is(`DTPM_REG_CODE, 32'hff, 32'h02);
    reg_is(`DTPM_REG_INFO, 32'h700, 32'h500);
    pm.fire(`DTPM_CODE_UV, 4'h0);
    settle();
    reg_is(`DTPM_REG_CODE, 32'hff, 32'h02);
    pm.fire(8'hd9, 4'h0);
    settle();
    reg_is(`DTPM_REG_CODE, 32'hff, 32'hd9);
    reg_is(`DTPM_REG_INFO, 32'h700, 32'h200);
    wr(`DTPM_REG_CTRL, 32'h100);
    reg_is(`DTPM_REG_INFO, 32'h8000, 32'h8000);
    pm.fire(8'hf5, 4'h0);
    settle();
    reg_is(`DTPM_REG_INFO, 32'h700, 32'h100);
    wr(`DTPM_REG_CTRL, 32'h100);
    chk({30'h0, trip_active_o, drive_inactive_o}, 32'h3);
    // overcurrent: early reset refused, encoder supply cannot override it
    hw_reset();
    pm.fire(`DTPM_CODE_OUTPUT_OVERCURRENT_TRIP, 4'h0);
    flag_is(1'b1);
    pm.fire(`DTPM_CODE_PS24, 4'h0);
    settle();
    reg_is(`DTPM_REG_CODE, 32'hff, 32'h03);
    wr(`DTPM_REG_CTRL, 32'h100);
    reg_is(`DTPM_REG_INFO, 32'h8000, 32'h8000);
    hw_reset();
    pm.fire(`DTPM_CODE_ENC2, 4'h0);
    flag_is(1'b1);
    pm.fire(`DTPM_CODE_PS24, 4'h0);
    settle();
    reg_is(`DTPM_REG_CODE, 32'hff, 32'h09);
    hw_reset();
    pm.fire(`DTPM_CODE_EEF, 4'h0);
    flag_is(1'b1);
    wr(`DTPM_REG_CTRL, 32'h100);
    reg_is(`DTPM_REG_INFO, 32'h8700, 32'h8300);
    // card trip category follows the power-up state
    for (int i = 0; i < 2; i++) begin
      power_up_i <= i[0];
      hw_reset();
      pm.fire(`DTPM_CODE_CARD_LO, 4'h0);
      flag_is(1'b1);
      reg_is(`DTPM_REG_INFO, 32'h700, i ? 32'h500 : 32'h400);
    end
    power_up_i <= 1'b0;
    // under-voltage ignores user reset and clears with the supply
    hw_reset();
    supply_ok_i <= 1'b0;
    settle(); // low supply must reach the block before the trip
    pm.fire(`DTPM_CODE_UV, 4'h0);
    flag_is(1'b1);
    wr(`DTPM_REG_CTRL, 32'h100);
    chk({31'h0, trip_active_o}, 32'h1);
    supply_ok_i <= 1'b1;
    flag_is(1'b0);
    // stop before trip for phase loss, light trips and overheat
    foreach (stops[i]) begin
      motor_stopped_i <= 1'b0; // settles through the synchroniser first
      hw_reset();
      wr(`DTPM_REG_CTRL, 32'h1);
      pm.fire(stops[i], 4'h0);
      settle();
      chk({30'h0, stop_request_o, trip_active_o}, 32'h2);
      motor_stopped_i <= 1'b1;
      flag_is(1'b1);
      reg_is(`DTPM_REG_CODE, 32'hff, {24'h0, stops[i]});
    end
    // single module: module number hidden, only some trips possible
    hw_reset();
    pm.fire(`DTPM_CODE_OIACP, 4'h3);
    settle();
    chk({31'h0, trip_active_o}, 32'h0);
    pm.fire(`DTPM_CODE_OIDCP, 4'h3);
    flag_is(1'b1);
    chk({28'h0, display_module_o}, 32'h0);
    reg_is(`DTPM_REG_INFO, 32'hf, 32'h0);
    parallel_if_i <= 1'b1;
    hw_reset();
    pm.fire(`DTPM_CODE_OIACP, 4'h2);
    flag_is(1'b1);
    chk({28'h0, display_module_o}, 32'h2);
    reg_is(`DTPM_REG_INFO, 32'hf, 32'h2);
    // mains and phase loss seen by the modules
    hw_reset();
    pm.mods(4'hf, 4'h3, 4'h0);
    flag_is(1'b1);
    reg_is(`DTPM_REG_CODE, 32'hff, 32'h6b);
    chk({31'h0, dc_bus_mains_loss_o}, 32'h0);
    pm.mods(4'hf, 4'h0, 4'h0);
    hw_reset();
    pm.mods(4'hf, 4'hf, 4'h0);
    settle();
    chk({30'h0, dc_bus_mains_loss_o, trip_active_o}, 32'h2);
    pm.mods(4'hf, 4'h0, 4'h0);
    hw_reset();
    pm.mods(4'hf, 4'h0, 4'h4);
    flag_is(1'b1);
    reg_is(`DTPM_REG_CODE, 32'hff, 32'h6b);
    summarize();
  end
endmodule
